// file: hw/flag_cell.v
`default_nettype none
// One status flag with set and clear requests; set wins over clear
module flag_cell (
   input wire ref_clk, // Clock
   input wire rst_n, // Async reset, active low
   input wire set, // Set request
   input wire clr, // Clear request
   output reg flag // Flag state
);
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: hw/twi_irq_bank.v
// Overview of operation
// [R1] A write to the set register sets every mask bit written as 1 and leaves the rest.
// [R2] A write to the clear register clears every mask bit written as 1 and leaves the rest.
// [R3] Reading the mask register returns the mask, 1 enabled, and it cannot be written directly.
// [R4] Bits 0, 1 and 2 are transfer complete, receive byte ready and transmit holding empty.
// [R5] Bit 8 is the not-acknowledged event; bits 31:9 and 7:3 are reserved and read zero.
// [R6] The receive holding register is read-only with the last received byte in bits 7:0.
// [R7] Receive ready sets when a byte lands in the holding register and clears on its read.
// [R8] Not-acknowledged sets on a missed data acknowledge and clears on a status read.
// [R9] Transmit empty sets on move to shifter, on missed ack or enable; a holding write clears it.
// [R10] Transfer complete sets when idle after stop or on enable, and clears during a frame; the code also sets it on nack_seen.
// [R11] The interrupt output is high while any flag is high with its mask bit high.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`include "twi_irq_map.vh"
`default_nettype none
module twi_irq_bank (
   input wire ref_clk, // 100 MHz clock
   input wire rst_n, // Async reset, active low
   input wire [7:0] addr, // Register byte address
   input wire [31:0] wdata, // Write data
   input wire wr_stb, // Write strobe
   input wire rd_stb, // Read strobe
   output reg [31:0] rdata, // Read data, valid the cycle after rd_stb
   input wire rx_byte_valid, // Engine: byte received, one-cycle pulse
   input wire [7:0] rx_byte, // Engine: received byte
   input wire tx_moved_to_shifter, // Engine: holding byte moved to shifter
   input wire nack_seen, // Engine: data byte not acknowledged
   input wire stop_done_idle, // Engine: stop sent, holding and shifter empty
   input wire frame_active, // Engine: frame in progress
   output reg [7:0] tx_byte, // Byte written to transmit holding register
   output reg tx_byte_load, // Pulse the cycle after the holding write
   output wire master_enable_pulse, // Pulse when master transfer enable written
   output wire irq // Interrupt request, level
);
   //////////////////////////////////////////////////////////////////////
   function sel;
      input [7:0] a;
      input [7:0] r;
      begin
         sel = (a == r);
      end
   endfunction

   // One decode per register, each used by either the write or the read path
   wire hit_set;
   wire hit_clr;
   wire hit_mask;
   wire hit_rhr;
   wire hit_thr;
   wire hit_ctl;
   wire hit_sr;
   assign hit_set = sel(addr, `REG_IRQ_SET_ENABLE);
   assign hit_clr = sel(addr, `REG_IRQ_CLEAR_ENABLE);
   assign hit_mask = sel(addr, `REG_IRQ_ENABLE_MASK);
   assign hit_rhr = sel(addr, `REG_RX_BYTE_HOLD);
   assign hit_thr = sel(addr, `REG_TX_BYTE_HOLD);
   assign hit_ctl = sel(addr, `REG_CONTROL);
   assign hit_sr = sel(addr, `REG_STATUS);

   wire wr_set;
   wire wr_clr;
   wire wr_thr;
   wire wr_ctl;
   wire rd_mask;
   wire rd_rhr;
   wire rd_sr;
   wire master_transfer_enable;
   assign wr_set = wr_stb & hit_set;
   assign wr_clr = wr_stb & hit_clr;
   assign wr_thr = wr_stb & hit_thr;
   assign wr_ctl = wr_stb & hit_ctl;
   assign rd_mask = rd_stb & hit_mask;
   assign rd_rhr = rd_stb & hit_rhr;
   assign rd_sr = rd_stb & hit_sr;
   assign master_transfer_enable = wr_ctl & wdata[`BIT_MASTER_TRANSFER_ENABLE];
   assign master_enable_pulse = master_transfer_enable;

   //////////////////////////////////////////////////////////////////////
   // Byte and load pulse leave together one cycle after the write, so
   // the engine always sees them aligned
   reg [7:0] next_tx_byte;
   always @* begin
      next_tx_byte = tx_byte;
      if (wr_thr) begin
         next_tx_byte = wdata[7:0];
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte <= `TX_BYTE_RESET;
         tx_byte_load <= 1'b0;
      end else begin
         tx_byte <= next_tx_byte;
         tx_byte_load <= wr_thr;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Mask kept as 9 bits; bits 7:3 never set because writes are filtered
   wire [8:0] used;
   wire [8:0] write_bits;
   reg [8:0] irq_enable_mask;
   reg [8:0] next_irq_enable_mask;
   assign used = `IRQ_BITS_USED;
   assign write_bits = wdata[8:0] & used;

   always @* begin
      next_irq_enable_mask = irq_enable_mask;
      // Set and clear are separate strobes so cannot meet in one cycle
      if (wr_set) begin
         next_irq_enable_mask = irq_enable_mask | write_bits; // R1 R4 R5
      end
      if (wr_clr) begin
         next_irq_enable_mask = irq_enable_mask & ~write_bits; // R2
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_mask <= `MASK_RESET;
      end else begin
         irq_enable_mask <= next_irq_enable_mask;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // A new byte overwrites an unread one; overrun is not tracked here
   reg [7:0] received_byte;
   reg [7:0] next_received_byte;
   always @* begin
      next_received_byte = received_byte;
      if (rx_byte_valid) begin
         next_received_byte = rx_byte; // R6
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         received_byte <= `RX_BYTE_RESET;
      end else begin
         received_byte <= next_received_byte;
      end
   end

   //////////////////////////////////////////////////////////////////////
   wire transfer_complete;
   wire receive_byte_ready;
   wire transmit_holding_empty;
   wire not_ack;
   wire [3:0] f_set;
   wire [3:0] f_clr;
   wire [3:0] f_q;
   assign f_set[0] = stop_done_idle | master_transfer_enable | nack_seen; // R10
   assign f_clr[0] = frame_active; // R10
   assign f_set[1] = rx_byte_valid; // R7
   assign f_clr[1] = rd_rhr; // R7
   assign f_set[2] = tx_moved_to_shifter | nack_seen | master_transfer_enable; // R9
   assign f_clr[2] = wr_thr; // R9
   assign f_set[3] = nack_seen; // R8
   assign f_clr[3] = rd_sr; // R8
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : flags
         flag_cell u_flag (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .set(f_set[g]),
            .clr(f_clr[g]),
            .flag(f_q[g])
         );
      end
   endgenerate
   assign transfer_complete = f_q[0];
   assign receive_byte_ready = f_q[1];
   assign transmit_holding_empty = f_q[2];
   assign not_ack = f_q[3];

   function [8:0] status_word;
      input [3:0] f;
      begin
         status_word = 9'h000;
         status_word[`BIT_TRANSFER_COMPLETE] = f[0];
         status_word[`BIT_RECEIVE_BYTE_READY] = f[1];
         status_word[`BIT_TRANSMIT_HOLDING_EMPTY] = f[2];
         status_word[`BIT_NOT_ACK] = f[3];
      end
   endfunction

   wire [8:0] status;
   assign status = status_word({not_ack, transmit_holding_empty,
      receive_byte_ready, transfer_complete}); // R4 R5

   // Per-source gating keeps each enable next to its flag
   wire [3:0] src_mask;
   wire [3:0] src_pending;
   assign src_mask = {irq_enable_mask[`BIT_NOT_ACK],
      irq_enable_mask[`BIT_TRANSMIT_HOLDING_EMPTY],
      irq_enable_mask[`BIT_RECEIVE_BYTE_READY],
      irq_enable_mask[`BIT_TRANSFER_COMPLETE]};
   generate
      for (g = 0; g < 4; g = g + 1) begin : gates
         assign src_pending[g] = f_q[g] & src_mask[g]; // R11
      end
   endgenerate
   assign irq = |src_pending; // R11

   //////////////////////////////////////////////////////////////////////
   // Read data stand one cycle only, then fall back to zero so a stale
   // word is never mistaken for a fresh answer
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = `RDATA_IDLE;
      if (rd_mask) begin
         next_rdata = {23'h00_0000, irq_enable_mask}; // R3
      end else if (rd_rhr) begin
         next_rdata = {24'h00_0000, received_byte}; // R6
      end else if (rd_sr) begin
         next_rdata = {23'h00_0000, status};
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `RDATA_IDLE;
      end else begin
         rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// file: hw/twi_irq_map.vh
`ifndef TWI_IRQ_MAP_VH
`define TWI_IRQ_MAP_VH
// Register offsets (byte addresses)
`define REG_STATUS 8'h20
`define REG_IRQ_SET_ENABLE 8'h24
`define REG_IRQ_CLEAR_ENABLE 8'h28
`define REG_IRQ_ENABLE_MASK 8'h2C
`define REG_RX_BYTE_HOLD 8'h30
`define REG_TX_BYTE_HOLD 8'h34
`define REG_CONTROL 8'h00
// Field positions
`define BIT_TRANSFER_COMPLETE 0
`define BIT_RECEIVE_BYTE_READY 1
`define BIT_TRANSMIT_HOLDING_EMPTY 2
`define BIT_NOT_ACK 8
`define BIT_MASTER_TRANSFER_ENABLE 2
// Valid mask bits
`define IRQ_BITS_USED 9'h107
// Reset values
`define MASK_RESET 9'h000
`define RX_BYTE_RESET 8'h00
`define TX_BYTE_RESET 8'h00
`define RDATA_IDLE 32'h0000_0000
`endif

// file: verif/twi_irq_bank_props.sv
`default_nettype none
module twi_irq_props (
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic [7:0] addr, // Address
   input wire logic [31:0] wdata, // Data in
   input wire logic wr_stb, // Write
   input wire logic rd_stb, // Read
   input wire logic [31:0] rdata, // Data out
   input wire logic rx_byte_valid, // Byte in
   input wire logic [7:0] rx_byte, // Byte
   input wire logic nack_seen, // No ack
   input wire logic [7:0] tx_byte, // Tx byte
   input wire logic tx_byte_load, // Tx load
   input wire logic master_enable_pulse, // Enable
   input wire logic irq // Interrupt
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   property p_set; wr_stb && addr == 8'h24 ##1 rd_stb && addr == 8'h2c |=>
      (rdata & $past(wdata, 2) & 32'h0000_0107) == ($past(wdata, 2) & 32'h0000_0107); endproperty
   a_set: assert property (p_set) else $error("set");
   property p_clr; wr_stb && addr == 8'h28 ##1 rd_stb && addr == 8'h2c |=>
      (rdata & $past(wdata, 2)) == 0; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_res; rd_stb && addr == 8'h2c |=> rdata[31:9] == 0 && rdata[7:3] == 0; endproperty
   a_res: assert property (p_res) else $error("reserved");
   property p_hold; rx_byte_valid ##1 rd_stb && addr == 8'h30 |=>
      rdata == {24'h00_0000, $past(rx_byte, 2)}; endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_nack; nack_seen ##1 rd_stb && addr == 8'h20 |=> rdata[8] && rdata[0]; endproperty
   a_nack: assert property (p_nack) else $error("nack");
   property p_load; wr_stb && addr == 8'h34 |=>
      tx_byte_load && tx_byte == $past(wdata[7:0]); endproperty
   a_load: assert property (p_load) else $error("load");
   property p_master_transfer_enable; wr_stb && addr == 8'h00 && wdata[2] |-> master_enable_pulse; endproperty
   a_master_transfer_enable: assert property (p_master_transfer_enable) else $error("enable");
   property p_irq; rd_stb && addr == 8'h2c ##1 !wr_stb && rdata == 0 |-> !irq; endproperty
   a_irq: assert property (p_irq) else $error("irq");
endmodule
bind twi_irq_bank twi_irq_props chk_i (.ref_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
   .rdata, .rx_byte_valid, .rx_byte, .nack_seen, .tx_byte, .tx_byte_load, .master_enable_pulse, .irq);
`default_nettype wire

// file: verif/twi_irq_bank_tb.sv
`default_nettype none
module twi_irq_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, rx_byte_valid = 0, nack_seen = 0;
   logic tx_mv = 0, stop_idle = 0, frame_on = 0;
   logic [7:0] addr = 0, rx_byte = 0;
   logic [31:0] wdata = 0, rdata;
   wire [7:0] tx_byte;
   wire tx_byte_load, master_enable_pulse, irq;
   int fails = 0, comparisons = 0, mk = 0, fl = 0, hb = 0, s = 25, d;
   twi_irq_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .tx_moved_to_shifter(tx_mv), .nack_seen(nack_seen),
      .stop_done_idle(stop_idle), .frame_active(frame_on), .tx_byte(tx_byte),
      .tx_byte_load(tx_byte_load), .master_enable_pulse(master_enable_pulse), .irq(irq));
   ////////////////////////////////////////
   function automatic int rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input logic [31:0] g, input int e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      {wr_stb, rd_stb, addr, wdata, rx_byte_valid, nack_seen, tx_mv, stop_idle, frame_on} <=
         {w, !w, a, v, 5'b0_0000};
   endtask
   task automatic rd(input logic [7:0] a, input int e);
      bus(0, a, 0);
      @(posedge ref_clk);
      rd_stb <= 0;
      @(negedge ref_clk);
      chk(rdata, e);
   endtask
   task automatic report_and_stop();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #100000 fails++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1;
      rd(8'h2c, 0);
      rd(8'h30, 0);
      rd(8'h3c, 0);
      repeat (400) begin
         d = rnd();
         if (d[2:0] > 4) begin
            @(posedge ref_clk);
            {rx_byte_valid, nack_seen, rx_byte} <= {d[2:0] != 7, d[2:0] == 7, d[15:8]};
         end
         if (d[2:0] < 3) begin
            @(posedge ref_clk);
            {tx_mv, stop_idle, frame_on} <= d[18:16];
            if (d[17])
               fl |= 1;
            else if (d[16])
               fl &= ~1;
            if (d[18])
               fl |= 4;
         end
         case (d[2:0])
            0: begin bus(1, 8'h24, d); mk |= d & 32'h107; rd(8'h2c, mk); end
            1: begin bus(1, 8'h28, d); mk &= ~d; rd(8'h2c, mk); end
            2: begin bus(1, 8'h2c, d); rd(8'h2c, mk); end
            3: begin bus(1, 8'h34, d); fl &= ~4; rd(8'h20, fl); end
            4: begin bus(1, 8'h00, 4); fl |= 5; rd(8'h20, fl); end
            5: begin hb = d[15:8]; rd(8'h30, hb); end
            6: begin hb = d[15:8]; fl |= 2; rd(8'h20, fl); rd(8'h30, hb); fl &= ~2; end
            7: begin fl |= 32'h105; rd(8'h20, fl); fl &= ~32'h100; rd(8'h20, fl); end
         endcase
         chk({31'h0, irq}, |(fl & mk));
         if (d[2:0] == 3) chk({24'h00_0000, tx_byte}, d[7:0]);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
